/* logic/dtpwm_timer.sv */
// Dual timer/counter with PWM and frequency outputs behind the special-function register port.

// Overview of operation
// - Mode 0: high byte counts via low-byte prescaler.
// - Mode 1: bytes cascade into 16-bit counter.
// - Mode 2: low byte reloads from high byte.
// - Timer a mode 3 splits into two counters.
// - Timer b mode 3 freezes its count.
// - Prescaler active bits equal width field plus one.
// - PWM enable drives waveform on count pin.
// - Flags and baud source keep working in PWM.
// - Output high at wrap, low at compare.
// - New duty applies only at wrap.
// - Duty zero keeps output low.
// - PWM mode 0 uses logarithmic prescaler.
// - Wrap copies duty into internal compare.
// - PWM mode 1 uses reloading linear prescaler.
// - PWM mode 2 toggles output per overflow.
// - PWM mode 3 gives two split PWM counters.
// - Split PWM channels use their own controls.
// - Mode 0 period scales with prescale width.
// - Mode 1 period scales with reload low.
// - Mode 2 frequency set by high byte.
// - Timer b stays baud source when a splits.
// - Overflow sets flag, vectoring clears it.
// - Count only when run and gate allow; split high of a needs only b's run bit.
// - Select bit picks clock or pin events.
module dtpwm_timer
  import dtpwm_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       system_timer_prescale_i,
  input  wire logic       ctr_a_ack_i,
  input  wire logic       ctr_b_ack_i,
  input  wire logic       ctr_a_pin_i,
  input  wire logic       ctr_b_pin_i,
  input  wire logic       ctr_a_gate_pin_i,
  input  wire logic       ctr_b_gate_pin_i,
  output logic            ctr_a_pin_o,
  output logic            ctr_a_pin_oe_n_o,
  output logic            ctr_b_pin_o,
  output logic            ctr_b_pin_oe_n_o,
  output logic            ctr_a_overflow_flag_o,
  output logic            ctr_b_overflow_flag_o,
  output logic            ctr_b_baud_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level is accepted once the second and third stages agree.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] pin_level;
  logic [3:0] raw_pins;
  logic [1:0] pin_fall;
  logic [1:0] gate_level;

  assign raw_pins   = {ctr_b_gate_pin_i, ctr_a_gate_pin_i, ctr_b_pin_i, ctr_a_pin_i};
  assign pin_fall   = pin_level[1:0] & ~sync2[1:0] & ~sync3[1:0];
  assign gate_level = pin_level[3:2];

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      pin_level <= '0;
    end
    else
    begin
      sync1     <= raw_pins;
      sync2     <= sync1;
      sync3     <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0]      timer_run_flag_control;
  logic [7:0]      timer_mode_select;
  logic [7:0]      pwm_prescale_config;
  logic [1:0][7:0] low_count_byte;
  logic [1:0][7:0] high_count_byte;
  logic [1:0][7:0] reload_low;
  logic [1:0][7:0] reload_high;
  logic [1:0][7:0] internal_compare;
  logic [7:0]      split_low_compare;
  logic [1:0]      pwm_level;
  logic            split_low_level;

  logic [1:0][7:0] next_low;
  logic [1:0][7:0] next_high;
  logic [1:0]      next_pwm_level;
  logic [1:0]      hi_wrap;
  logic [1:0]      own_ovf;
  logic [1:0]      pwm_hi_en;
  logic [1:0][1:0] mode;
  logic [1:0]      cnt_inc;
  logic [1:0]      hi_inc;
  logic [1:0]      wr_low;
  logic [1:0]      wr_high;
  logic [1:0]      wr_rl;
  logic [1:0]      wr_rh;
  logic            wr_timer_run_flag_control;
  logic            wr_timer_mode_select;
  logic            wr_pwm_prescale_config;
  logic            tick;
  logic            split_a;
  logic            lo_wrap;
  logic            next_split_low;
  logic            set_flag_a;
  logic            set_flag_b;
  logic [7:0]      timer_run_flag_control_base;
  logic [7:0]      next_timer_run_flag_control;

  assign tick    = system_timer_prescale_i;
  assign split_a = (mode[0] == MODE_SPLIT);

  assign wr_timer_run_flag_control  = sfr_wr_i && (sfr_addr_i == ADDR_TIMER_RUN_FLAG_CONTROL);
  assign wr_timer_mode_select  = sfr_wr_i && (sfr_addr_i == ADDR_TIMER_MODE_SELECT);
  assign wr_pwm_prescale_config = sfr_wr_i && (sfr_addr_i == ADDR_PWM_PRESCALE_CONFIG);
  assign wr_low   = {sfr_wr_i && (sfr_addr_i == ADDR_CTR_B_COUNT_LOW),
                     sfr_wr_i && (sfr_addr_i == ADDR_CTR_A_COUNT_LOW)};
  assign wr_high  = {sfr_wr_i && (sfr_addr_i == ADDR_CTR_B_COUNT_HIGH),
                     sfr_wr_i && (sfr_addr_i == ADDR_CTR_A_COUNT_HIGH)};
  assign wr_rl    = {sfr_wr_i && (sfr_addr_i == ADDR_CTR_B_RELOAD_LOW),
                     sfr_wr_i && (sfr_addr_i == ADDR_CTR_A_RELOAD_LOW)};
  assign wr_rh    = {sfr_wr_i && (sfr_addr_i == ADDR_CTR_B_RELOAD_HIGH),
                     sfr_wr_i && (sfr_addr_i == ADDR_CTR_A_RELOAD_HIGH)};

  ////////////////////////////////////////////////////////////////////////////////
  // Per-timer counting.
  for (genvar i = 0; i < 2; i++)
  begin : g_timer
    logic [7:0] tl;
    logic [7:0] th;
    logic [7:0] tl_plus;
    logic [7:0] th_plus;
    logic [7:0] mask;
    logic [2:0] psc;
    logic       pwm_en;
    logic       gate;
    logic       count_sel;
    logic       run;
    logic       frozen;
    logic       evt;
    logic       pre_full;
    logic       tl_ovf;
    logic       full16;
    logic       reload16;
    logic       match;

    assign tl        = low_count_byte[i];
    assign th        = high_count_byte[i];
    assign tl_plus   = tl + BYTE_ONE;
    assign th_plus   = th + BYTE_ONE;
    assign mode[i]   = timer_mode_select[MODE_NIBBLE*i + BIT_MODE_LO +: 2];
    assign gate      = timer_mode_select[MODE_NIBBLE*i + BIT_GATE];
    assign count_sel = timer_mode_select[MODE_NIBBLE*i + BIT_COUNT_SEL];
    assign pwm_en    = pwm_prescale_config[BIT_CTR_A_PWM_ENABLE + i];
    assign psc       = pwm_prescale_config[PSC_WIDTH*i +: PSC_WIDTH];
    // Width field plus one low-byte bits form the prescaler.
    assign mask      = BYTE_ONES >> (PSC_TOP - psc);
    // Timer b in mode 3 holds exactly as if its run bit were clear.
    assign frozen    = (i == 1) && (mode[i] == MODE_SPLIT);
    assign run       = timer_run_flag_control[BIT_CTR_A_RUN + RUN_FLAG_STRIDE*i]
                       && (!gate || gate_level[i]) && !frozen;
    // PWM owns the pin, so the timer then always counts clocks.
    assign evt       = (pwm_en || !count_sel) ? tick : pin_fall[i];
    assign cnt_inc[i] = run && evt;
    assign pre_full  = ((tl & mask) == mask);
    assign tl_ovf    = (tl == BYTE_ONES);
    assign full16    = tl_ovf && (th == BYTE_ONES);
    assign reload16  = (mode[i] == MODE_AUTO16) && !pwm_en && cnt_inc[i] && full16;

    // The split high byte of timer a runs on timer b's run bit and clocks only.
    assign hi_inc[i] =
        (mode[i] == MODE_VAR_WIDTH) ? (cnt_inc[i] && pre_full) :
        (mode[i] == MODE_AUTO16)    ? (cnt_inc[i] && tl_ovf) :
        (mode[i] == MODE_SPLIT && i == 0) ?
          (timer_run_flag_control[BIT_CTR_B_RUN] && tick) : 1'b0;

    assign next_low[i] =
        !cnt_inc[i] ? tl :
        (mode[i] == MODE_VAR_WIDTH) ? (pre_full ? BYTE_ZERO : (tl_plus & mask)) :
        (mode[i] == MODE_AUTO16)    ? ((pwm_en ? tl_ovf : full16) ?
                                       reload_low[i] : tl_plus) :
        (mode[i] == MODE_AUTO8)     ? (tl_ovf ? th : tl_plus) :
        tl_plus;

    assign next_high[i] = reload16 ? reload_high[i] : (hi_inc[i] ? th_plus : th);

    assign hi_wrap[i] = hi_inc[i] && (th == BYTE_ONES);
    // Own flag: low-byte overflow in modes 2 and 3, else high-byte wrap.
    assign own_ovf[i] = mode[i][1] ? (cnt_inc[i] && tl_ovf) : hi_wrap[i];

    // In split mode the high counter answers to timer b's PWM enable.
    assign pwm_hi_en[i] = (i == 0 && mode[i] == MODE_SPLIT) ?
                          pwm_prescale_config[BIT_CTR_A_PWM_ENABLE + 1] : pwm_en;
    assign match = hi_inc[i] && (th_plus == internal_compare[i]);

    assign next_pwm_level[i] =
        !pwm_hi_en[i]              ? 1'b0 :
        (mode[i] == MODE_AUTO8)    ? (pwm_level[i] ^ own_ovf[i]) :
        (frozen)                   ? pwm_level[i] :
        hi_wrap[i]                 ? (reload_high[i] != BYTE_ZERO) :
        match                      ? 1'b0 : pwm_level[i];
  end

  // Split PWM low counter of timer a, duty taken from its reload-low register.
  assign lo_wrap        = split_a && cnt_inc[0] && (low_count_byte[0] == BYTE_ONES);
  assign next_split_low =
      !(split_a && pwm_prescale_config[BIT_CTR_A_PWM_ENABLE]) ? 1'b0 :
      lo_wrap ? (reload_low[0] != BYTE_ZERO) :
      (cnt_inc[0] && (low_count_byte[0] + BYTE_ONE == split_low_compare)) ? 1'b0 :
      split_low_level;

  ////////////////////////////////////////////////////////////////////////////////
  // Flags: a hardware set wins over an acknowledge or a software write in the same cycle.
  assign set_flag_a = own_ovf[0];
  assign set_flag_b = split_a ? hi_wrap[0] : own_ovf[1];
  assign timer_run_flag_control_base  = wr_timer_run_flag_control ? sfr_wdata_i : timer_run_flag_control;
  always_comb
  begin
    next_timer_run_flag_control = timer_run_flag_control_base;
    next_timer_run_flag_control[BIT_CTR_A_OVERFLOW_FLAG] = set_flag_a ||
        (timer_run_flag_control_base[BIT_CTR_A_OVERFLOW_FLAG] && !ctr_a_ack_i);
    next_timer_run_flag_control[BIT_CTR_B_OVERFLOW_FLAG] = set_flag_b ||
        (timer_run_flag_control_base[BIT_CTR_B_OVERFLOW_FLAG] && !ctr_b_ack_i);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      timer_run_flag_control <= RST_TIMER_RUN_FLAG_CONTROL;
      timer_mode_select      <= RST_TIMER_MODE_SELECT;
      pwm_prescale_config    <= RST_PWM_PRESCALE_CONFIG;
      split_low_compare      <= RST_COUNT;
      split_low_level        <= 1'b0;
      pwm_level              <= '0;
      ctr_b_baud_o           <= 1'b0;
    end
    else
    begin
      timer_run_flag_control <= next_timer_run_flag_control;
      timer_mode_select      <= wr_timer_mode_select ? sfr_wdata_i : timer_mode_select;
      pwm_prescale_config    <= wr_pwm_prescale_config ? sfr_wdata_i : pwm_prescale_config;
      split_low_compare      <= lo_wrap ? reload_low[0] : split_low_compare;
      split_low_level        <= next_split_low;
      pwm_level              <= next_pwm_level;
      // Timer b keeps feeding the serial port even when it cannot interrupt.
      ctr_b_baud_o           <= own_ovf[1];
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_regs
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        low_count_byte[i]   <= RST_COUNT;
        high_count_byte[i]  <= RST_COUNT;
        reload_low[i]       <= RST_COUNT;
        reload_high[i]      <= RST_COUNT;
        internal_compare[i] <= RST_COUNT;
      end
      else
      begin
        // A software write to a count byte wins over counting in that cycle.
        low_count_byte[i]   <= wr_low[i] ? sfr_wdata_i : next_low[i];
        high_count_byte[i]  <= wr_high[i] ? sfr_wdata_i : next_high[i];
        reload_low[i]       <= wr_rl[i] ? sfr_wdata_i : reload_low[i];
        reload_high[i]      <= wr_rh[i] ? sfr_wdata_i : reload_high[i];
        internal_compare[i] <= hi_wrap[i] ? reload_high[i] : internal_compare[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and pins.
  assign sfr_rdata_o =
      (sfr_addr_i == ADDR_TIMER_RUN_FLAG_CONTROL) ? timer_run_flag_control :
      (sfr_addr_i == ADDR_TIMER_MODE_SELECT)      ? timer_mode_select :
      (sfr_addr_i == ADDR_CTR_A_COUNT_LOW)        ? low_count_byte[0] :
      (sfr_addr_i == ADDR_CTR_B_COUNT_LOW)        ? low_count_byte[1] :
      (sfr_addr_i == ADDR_CTR_A_COUNT_HIGH)       ? high_count_byte[0] :
      (sfr_addr_i == ADDR_CTR_B_COUNT_HIGH)       ? high_count_byte[1] :
      (sfr_addr_i == ADDR_PWM_PRESCALE_CONFIG)    ? pwm_prescale_config :
      (sfr_addr_i == ADDR_CTR_A_RELOAD_LOW)       ? reload_low[0] :
      (sfr_addr_i == ADDR_CTR_B_RELOAD_LOW)       ? reload_low[1] :
      (sfr_addr_i == ADDR_CTR_A_RELOAD_HIGH)      ? reload_high[0] :
      (sfr_addr_i == ADDR_CTR_B_RELOAD_HIGH)      ? reload_high[1] : BYTE_ZERO;

  assign ctr_a_pin_o      = split_a ? split_low_level : pwm_level[0];
  assign ctr_b_pin_o      = split_a ? pwm_level[0] : pwm_level[1];
  assign ctr_a_pin_oe_n_o = !pwm_prescale_config[BIT_CTR_A_PWM_ENABLE];
  assign ctr_b_pin_oe_n_o = !pwm_prescale_config[BIT_CTR_A_PWM_ENABLE + 1];
  assign ctr_a_overflow_flag_o = timer_run_flag_control[BIT_CTR_A_OVERFLOW_FLAG];
  assign ctr_b_overflow_flag_o = timer_run_flag_control[BIT_CTR_B_OVERFLOW_FLAG];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  reload_auto8_a: assert property (
    (mode[0] == MODE_AUTO8 && cnt_inc[0] && low_count_byte[0] == BYTE_ONES && !sfr_wr_i)
    |=> (low_count_byte[0] == $past(high_count_byte[0])) && $stable(high_count_byte[0]))
    else $error("auto8 reload wrong");
  reload_auto16_a: assert property (
    (mode[0] == MODE_AUTO16 && !pwm_prescale_config[BIT_CTR_A_PWM_ENABLE] && cnt_inc[0]
     && {high_count_byte[0], low_count_byte[0]} == 16'hFFFF && !sfr_wr_i)
    |=> {high_count_byte[0], low_count_byte[0]} == {$past(reload_high[0]), $past(reload_low[0])})
    else $error("auto16 reload wrong");
  b_frozen_a: assert property (
    (mode[1] == MODE_SPLIT && !sfr_wr_i)
    |=> $stable(low_count_byte[1]) && $stable(high_count_byte[1]))
    else $error("timer b moved in mode 3");
  gate_block_a: assert property (
    (!split_a && timer_mode_select[BIT_GATE] && !gate_level[0] && !sfr_wr_i)
    |=> $stable(low_count_byte[0]))
    else $error("gated timer counted");
  compare_load_a: assert property (
    hi_wrap[0] |=> internal_compare[0] == $past(reload_high[0]))
    else $error("compare not loaded at wrap");
  compare_hold_a: assert property (
    !hi_wrap[0] |=> $stable(internal_compare[0]))
    else $error("compare changed outside wrap");
  pwm_rise_a: assert property (
    (pwm_hi_en[0] && mode[0] != MODE_AUTO8 && hi_wrap[0] && reload_high[0] != BYTE_ZERO)
    |=> pwm_level[0])
    else $error("pwm not high after wrap");
  duty_zero_a: assert property (
    (pwm_hi_en[0] && mode[0] != MODE_AUTO8 && hi_wrap[0] && reload_high[0] == BYTE_ZERO)
    |=> !pwm_level[0])
    else $error("zero duty not low");
  toggle_auto8_a: assert property (
    (pwm_hi_en[0] && mode[0] == MODE_AUTO8 && own_ovf[0])
    |=> pwm_level[0] != $past(pwm_level[0]))
    else $error("square wave did not toggle");
  flag_set_a: assert property (
    set_flag_a |=> ctr_a_overflow_flag_o ##0 $past(set_flag_a))
    else $error("overflow flag not set");
  pwm_off_a: assert property (
    !pwm_hi_en[1] |=> !pwm_level[1])
    else $error("disabled pwm not low");

  pwm_wrap_c: cover property (pwm_hi_en[0] && hi_wrap[0] ##[1:300] !pwm_level[0]);
  split_c:    cover property (split_a && set_flag_b);
  baud_c:     cover property (split_a && ctr_b_baud_o);

endmodule

/* logic/dtpwm_pkg.sv */
// Register map, field positions, mode codes and reset values of the dual timer.
package dtpwm_pkg;

  // Special-function register addresses.
  localparam logic [7:0] ADDR_TIMER_RUN_FLAG_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT      = 8'h89;
  localparam logic [7:0] ADDR_CTR_A_COUNT_LOW        = 8'h8A;
  localparam logic [7:0] ADDR_CTR_B_COUNT_LOW        = 8'h8B;
  localparam logic [7:0] ADDR_CTR_A_COUNT_HIGH       = 8'h8C;
  localparam logic [7:0] ADDR_CTR_B_COUNT_HIGH       = 8'h8D;
  localparam logic [7:0] ADDR_PWM_PRESCALE_CONFIG    = 8'h91;
  localparam logic [7:0] ADDR_CTR_A_RELOAD_LOW       = 8'h92;
  localparam logic [7:0] ADDR_CTR_B_RELOAD_LOW       = 8'h93;
  localparam logic [7:0] ADDR_CTR_A_RELOAD_HIGH      = 8'h94;
  localparam logic [7:0] ADDR_CTR_B_RELOAD_HIGH      = 8'h95;

  // Reset values.
  localparam logic [7:0] RST_TIMER_RUN_FLAG_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_MODE_SELECT      = 8'h00;
  localparam logic [7:0] RST_PWM_PRESCALE_CONFIG    = 8'h24;
  localparam logic [7:0] RST_COUNT                  = 8'h00;

  // Run/flag control fields; timer b sits two bits above timer a.
  localparam int BIT_CTR_A_RUN           = 4;
  localparam int BIT_CTR_A_OVERFLOW_FLAG = 5;
  localparam int BIT_CTR_B_RUN           = 6;
  localparam int BIT_CTR_B_OVERFLOW_FLAG = 7;
  localparam int RUN_FLAG_STRIDE         = 2;

  // Mode select fields; each timer owns one nibble.
  localparam int MODE_NIBBLE   = 4;
  localparam int BIT_MODE_LO   = 0;
  localparam int BIT_COUNT_SEL = 2;
  localparam int BIT_GATE      = 3;

  // Prescale/PWM configuration fields.
  localparam int BIT_CTR_A_PWM_ENABLE = 6;
  localparam int PSC_WIDTH            = 3;
  localparam logic [2:0] PSC_TOP      = 3'h7;

  // Operating modes.
  localparam logic [1:0] MODE_VAR_WIDTH = 2'h0;
  localparam logic [1:0] MODE_AUTO16    = 2'h1;
  localparam logic [1:0] MODE_AUTO8     = 2'h2;
  localparam logic [1:0] MODE_SPLIT     = 2'h3;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE  = 8'h01;

endpackage

/* tb/dtpwm_pin_model.sv */
// Far-side model of the count, gate and PWM pins of both timers.
module dtpwm_pin_model (
  input  wire logic clk_i,
  input  wire logic a_out_i,
  input  wire logic a_oe_n_i,
  input  wire logic b_out_i,
  input  wire logic b_oe_n_i,
  output logic      a_pin_o,
  output logic      b_pin_o,
  output logic      a_gate_o,
  output logic      b_gate_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic a_drv = 1'b1;
  initial
  begin
    a_gate_o = 1'b1;
    b_gate_o = 1'b1;
  end
  // The source lets go while the timer drives the pin; pin b has only the pull-up, which holds it high while undriven.
  assign a_pin_o = a_oe_n_i ? a_drv : a_out_i;
  assign b_pin_o = b_oe_n_i ? 1'b1 : b_out_i;
  // Each level stands four clocks so that it survives the pin synchroniser.
  task automatic falls(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_i);
      a_drv <= 1'b0;
      repeat (4) @(posedge clk_i);
      a_drv <= 1'b1;
    end
  endtask
  task automatic gate(input logic v);
    @(posedge clk_i);
    a_gate_o <= v;
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the dual timer: registers, timer modes, pin counting and PWM.
module tb_top
  import dtpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, nrst, wr, tick, ack_a, ack_b, pin_a, pin_b, gate_a, gate_b;
  logic       out_a, oe_n_a, out_b, oe_n_b, flag_a, flag_b, baud;
  logic [7:0] addr, wdata, rdata;
  int         miscompares = 0;
  int         tests_run = 0;
  int         baud_cnt = 0;
  int         hi, per;
  ////////////////////////////////////////////////////////////////////////
  dtpwm_timer i_dut (
    .core_clk_i(clk), .nrst_i(nrst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .system_timer_prescale_i(tick),
    .ctr_a_ack_i(ack_a), .ctr_b_ack_i(ack_b), .ctr_a_pin_i(pin_a), .ctr_b_pin_i(pin_b),
    .ctr_a_gate_pin_i(gate_a), .ctr_b_gate_pin_i(gate_b), .ctr_a_pin_o(out_a),
    .ctr_a_pin_oe_n_o(oe_n_a), .ctr_b_pin_o(out_b), .ctr_b_pin_oe_n_o(oe_n_b),
    .ctr_a_overflow_flag_o(flag_a), .ctr_b_overflow_flag_o(flag_b), .ctr_b_baud_o(baud));
  dtpwm_pin_model i_pins (
    .clk_i(clk), .a_out_i(out_a), .a_oe_n_i(oe_n_a), .b_out_i(out_b), .b_oe_n_i(oe_n_b),
    .a_pin_o(pin_a), .b_pin_o(pin_b), .a_gate_o(gate_a), .b_gate_o(gate_b));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (baud === 1'b1) baud_cnt <= baud_cnt + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s: %h, expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp}, what);
  endtask
  task automatic ticks(input int n);
    @(posedge clk);
    tick <= 1'b1;
    repeat (n) @(posedge clk);
    tick <= 1'b0;
  endtask
  // Counts high samples and samples in all from now up to and including the next rise.
  task automatic period(input bit sel);
    logic prev;
    logic now;
    prev = sel ? out_b : out_a;
    hi = 0;
    per = 0;
    for (int k = 0; k <= 1200; k++)
    begin
      if (k == 1200)
      begin
        miscompares++;
        finish_test();
      end
      @(negedge clk);
      now = sel ? out_b : out_a;
      per++;
      hi += (now === 1'b1);
      if (now === 1'b1 && prev === 1'b0) break;
      prev = now;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic sc_timers();
    rdc(ADDR_PWM_PRESCALE_CONFIG, RST_PWM_PRESCALE_CONFIG, "psc reset");
    rdc(8'h90, BYTE_ZERO, "unmapped");
    chk({14'h0000, out_a, out_b}, 16'h0000, "pwm idle");
    wrr(ADDR_TIMER_MODE_SELECT, 8'h02);
    wrr(ADDR_CTR_A_COUNT_HIGH, 8'hF0);
    wrr(ADDR_CTR_A_COUNT_LOW, 8'hFE);
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h10);
    ticks(2);
    rdc(ADDR_CTR_A_COUNT_LOW, 8'hF0, "reload");
    rdc(ADDR_CTR_A_COUNT_HIGH, 8'hF0, "high kept");
    rdc(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h30, "flag a set");
    chk({15'h0000, flag_a}, 16'h0001, "flag a pin");
    @(posedge clk);
    ack_a <= 1'b1;
    @(posedge clk);
    ack_a <= 1'b0;
    rdc(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h10, "flag a ack");
    wrr(ADDR_TIMER_MODE_SELECT, 8'h10);
    wrr(ADDR_CTR_B_RELOAD_LOW, 8'h34);
    wrr(ADDR_CTR_B_RELOAD_HIGH, 8'h12);
    wrr(ADDR_CTR_B_COUNT_LOW, 8'hFE);
    wrr(ADDR_CTR_B_COUNT_HIGH, 8'hFF);
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h40);
    ticks(2);
    rdc(ADDR_CTR_B_COUNT_LOW, 8'h34, "16 low");
    rdc(ADDR_CTR_B_COUNT_HIGH, 8'h12, "16 high");
    chk({15'h0000, flag_b}, 16'h0001, "flag b");
    chk(16'(baud_cnt), 16'h0001, "baud");
    wrr(ADDR_TIMER_MODE_SELECT, 8'h30);
    ticks(5);
    rdc(ADDR_CTR_B_COUNT_LOW, 8'h34, "frozen");
  endtask
  task automatic sc_var_split();
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    wrr(ADDR_TIMER_MODE_SELECT, 8'h00);
    wrr(ADDR_CTR_A_COUNT_LOW, 8'h1E);
    wrr(ADDR_CTR_A_COUNT_HIGH, 8'h00);
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h10);
    ticks(3);
    rdc(ADDR_CTR_A_COUNT_LOW, 8'h01, "5 bit low");
    rdc(ADDR_CTR_A_COUNT_HIGH, 8'h01, "5 bit high");
    wrr(ADDR_PWM_PRESCALE_CONFIG, 8'h20);
    wrr(ADDR_CTR_A_COUNT_LOW, 8'h00);
    ticks(4);
    rdc(ADDR_CTR_A_COUNT_HIGH, 8'h03, "1 bit high");
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    wrr(ADDR_TIMER_MODE_SELECT, 8'h03);
    wrr(ADDR_CTR_A_COUNT_LOW, 8'hFF);
    wrr(ADDR_CTR_A_COUNT_HIGH, 8'hFF);
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h50);
    ticks(1);
    rdc(ADDR_CTR_A_COUNT_LOW, 8'h00, "split low");
    rdc(ADDR_TIMER_RUN_FLAG_CONTROL, 8'hF0, "split flags");
    wrr(ADDR_TIMER_MODE_SELECT, 8'h23);
    wrr(ADDR_CTR_B_COUNT_LOW, 8'hFF);
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h40);
    ticks(1);
    rdc(ADDR_CTR_B_COUNT_LOW, 8'h12, "b reload in split");
    rdc(ADDR_CTR_A_COUNT_HIGH, 8'h01, "split high on b run");
    rdc(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h40, "b silent in split");
    chk(16'(baud_cnt), 16'h0002, "baud in split");
  endtask
  task automatic sc_pins();
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    wrr(ADDR_TIMER_MODE_SELECT, 8'h0E);
    wrr(ADDR_CTR_A_COUNT_LOW, 8'h00);
    wrr(ADDR_CTR_A_COUNT_HIGH, 8'h00);
    i_pins.gate(1'b0);
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h10);
    i_pins.falls(2);
    rdc(ADDR_CTR_A_COUNT_LOW, 8'h00, "gated");
    i_pins.gate(1'b1);
    repeat (5) @(posedge clk);
    i_pins.falls(3);
    repeat (5) @(posedge clk);
    rdc(ADDR_CTR_A_COUNT_LOW, 8'h03, "pin events");
  endtask
  task automatic sc_pwm();
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h00);
    wrr(ADDR_TIMER_MODE_SELECT, 8'h21);
    wrr(ADDR_CTR_A_RELOAD_LOW, 8'hFF);
    wrr(ADDR_CTR_A_RELOAD_HIGH, 8'h02);
    wrr(ADDR_CTR_B_COUNT_HIGH, 8'hFC);
    wrr(ADDR_PWM_PRESCALE_CONFIG, 8'hE4);
    @(negedge clk);
    chk({14'h0000, oe_n_a, oe_n_b}, 16'h0000, "pin drive");
    wrr(ADDR_TIMER_RUN_FLAG_CONTROL, 8'h50);
    @(posedge clk);
    tick <= 1'b1;
    period(1'b0);
    period(1'b0);
    chk(16'(hi), 16'h0002, "duty 2");
    chk(16'(per), 16'h0100, "mode 1 period");
    fork
      period(1'b0);
      begin
        repeat (20) @(posedge clk);
        wrr(ADDR_CTR_A_RELOAD_HIGH, 8'h05);
      end
    join
    chk(16'(hi), 16'h0002, "duty held");
    period(1'b0);
    chk(16'(hi), 16'h0005, "duty 5");
    wrr(ADDR_CTR_A_RELOAD_HIGH, 8'h00);
    repeat (300) @(negedge clk);
    hi = 0;
    repeat (300)
    begin
      @(negedge clk);
      hi += (out_a === 1'b1);
    end
    chk(16'(hi), 16'h0000, "duty 0");
    period(1'b1);
    period(1'b1);
    chk(16'(hi), 16'h0004, "square high");
    chk(16'(per), 16'h0008, "square period");
    chk({15'h0000, flag_b}, 16'h0001, "pwm flag");
    wrr(ADDR_TIMER_MODE_SELECT, 8'h00);
    wrr(ADDR_CTR_A_RELOAD_HIGH, 8'h02);
    wrr(ADDR_PWM_PRESCALE_CONFIG, 8'h60);
    period(1'b0);
    period(1'b0);
    chk(16'(hi), 16'h0004, "mode 0 duty");
    chk(16'(per), 16'h0200, "mode 0 period");
    wrr(ADDR_CTR_A_RELOAD_LOW, 8'h03);
    wrr(ADDR_TIMER_MODE_SELECT, 8'h03);
    wrr(ADDR_PWM_PRESCALE_CONFIG, 8'hC0);
    period(1'b0);
    period(1'b0);
    chk(16'(hi), 16'h0003, "split low duty");
    chk(16'(per), 16'h0100, "split low period");
    period(1'b1);
    period(1'b1);
    chk(16'(hi), 16'h0002, "split high duty");
    chk(16'(per), 16'h0100, "split high period");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, wr, tick, ack_a, ack_b} = 5'h00;
    addr  = 8'h00;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    sc_timers();
    sc_var_split();
    sc_pins();
    sc_pwm();
    finish_test();
  end
endmodule
